// ==== rtl/nvsc_host.sv ====
// host controller that drives the nvsram strobes, sequences and save requests
`timescale 1ns/1ps
`default_nettype none
module nvsc_host #(
  parameter int POWERUP_CYC = nvsc_pkg::POWERUP_RESTORE_TIME_CYC,
  parameter int PROC_CYC    = nvsc_pkg::COMMAND_PROCESSING_TIME_CYC
) (
  // clock and reset
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_rst,
  // user request
  input  wire logic                        i_req_valid,
  input  wire logic [1:0]                  i_req_cmd,
  input  wire logic [nvsc_pkg::ADDR_W-1:0] i_req_addr,
  input  wire logic [nvsc_pkg::DATA_W-1:0] i_req_wdata,
  input  wire logic                        i_hw_save_req,
  output logic                             o_req_ready,
  output logic                             o_rsp_valid,
  output logic [nvsc_pkg::DATA_W-1:0]      o_rsp_rdata,
  // memory pins
  output logic [nvsc_pkg::ADDR_W-1:0]      o_mem_addr,
  output logic                             o_mem_sel_n,
  output logic                             o_mem_wr_n,
  output logic                             o_mem_oe_n,
  input  wire logic [nvsc_pkg::DATA_W-1:0] i_mem_dq,
  output logic [nvsc_pkg::DATA_W-1:0]      o_mem_dq,
  output logic                             o_mem_dq_oe,
  input  wire logic                        i_hw_save_busy_n,
  output logic                             o_hw_save_busy_n,
  output logic                             o_hw_save_busy_oe
);
  localparam int CW = nvsc_pkg::CNT_W;

  function automatic logic [CW-1:0] cyc(input int n);
    cyc = CW'(n);
  endfunction : cyc

  function automatic logic [14:0] seq_addr(input logic [2:0] idx, input logic rec);
    case (idx)
      3'h0: seq_addr = nvsc_pkg::SEQ_A0;
      3'h1: seq_addr = nvsc_pkg::SEQ_A1;
      3'h2: seq_addr = nvsc_pkg::SEQ_A2;
      3'h3: seq_addr = nvsc_pkg::SEQ_A3;
      3'h4: seq_addr = nvsc_pkg::SEQ_A4;
      default: seq_addr = rec ? nvsc_pkg::SEQ_RECALL : nvsc_pkg::SEQ_STORE;
    endcase
  endfunction : seq_addr

  nvsc_pkg::nvsc_state_t state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [2:0] seq_idx_r, seq_idx_nxt;
  logic [1:0] cmd_r, cmd_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic [14:0] uaddr_r, uaddr_nxt;
  logic busy_pin_s;
  logic [7:0] dq_s;

  // pin inputs cross two flops before use
  nvsc_sync #(.W(1)) u_sync_busy (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_async   (i_hw_save_busy_n),
    .o_sync    (busy_pin_s)
  );
  nvsc_sync #(.W(8)) u_sync_dq (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_async   (i_mem_dq),
    .o_sync    (dq_s)
  );

  wire is_seq    = cmd_r[1];
  wire is_write  = (cmd_r == nvsc_pkg::CMD_WRITE) && !is_seq;
  wire last_seq  = is_seq && (seq_idx_r == 3'(nvsc_pkg::SEQ_LEN - 1));
  // two extra access cycles cover the data synchroniser
  wire [CW-1:0] acc_cyc = is_write ? cyc(nvsc_pkg::WRITE_PULSE_CYC) : cyc(nvsc_pkg::DATA_ACCESS_CYC + 2);
  wire cnt_done  = (cnt_r == '0);
  wire take_req  = (state_r == nvsc_pkg::NVSC_IDLE) && i_req_valid && !i_hw_save_req;
  wire take_hw   = (state_r == nvsc_pkg::NVSC_IDLE) && i_hw_save_req;
  wire dev_busy  = !busy_pin_s;
  // reads sample synchronised data on the strobe's last cycle; sixth command read discarded
  wire rsp_fire  = (state_r == nvsc_pkg::NVSC_ACCESS) && cnt_done && !is_seq
                   && !is_write; // see R11
  wire done_fire = ((state_r == nvsc_pkg::NVSC_ACCESS) && cnt_done && (is_write || !is_seq))
                   || ((state_r == nvsc_pkg::NVSC_BUSY) && cnt_done && !dev_busy);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_done ? cnt_r : cnt_r - cyc(1);
    seq_idx_nxt = seq_idx_r;
    cmd_nxt = cmd_r;
    wdata_nxt = wdata_r;
    uaddr_nxt = uaddr_r;
    case (state_r)
      nvsc_pkg::NVSC_POWERUP: begin
        // restore after power-up blocks every access
        if (cnt_done) state_nxt = nvsc_pkg::NVSC_IDLE; // see R5
      end
      nvsc_pkg::NVSC_IDLE: begin
        if (take_hw) begin
          state_nxt = nvsc_pkg::NVSC_HWREQ;
          cnt_nxt = cyc(nvsc_pkg::HW_SAVE_PULSE_MIN_CYC - 1); // see R12
        end else if (take_req) begin
          cmd_nxt = i_req_cmd;
          wdata_nxt = i_req_wdata;
          uaddr_nxt = i_req_addr;
          seq_idx_nxt = '0;
          state_nxt = nvsc_pkg::NVSC_ACCESS;
          cnt_nxt = (i_req_cmd == nvsc_pkg::CMD_WRITE) ? cyc(nvsc_pkg::WRITE_PULSE_CYC)
                                                       : cyc(nvsc_pkg::DATA_ACCESS_CYC + 2);
        end
      end
      nvsc_pkg::NVSC_ACCESS: begin
        if (cnt_done) begin
          state_nxt = nvsc_pkg::NVSC_GAP;
          cnt_nxt = cyc(nvsc_pkg::READ_CYCLE_CYC - 1);
        end
      end
      nvsc_pkg::NVSC_GAP: begin
        // strobes high between cycles; command reads follow one another directly
        if (cnt_done) begin
          if (is_seq && !last_seq) begin
            seq_idx_nxt = seq_idx_r + 3'h1; // see R7
            state_nxt = nvsc_pkg::NVSC_ACCESS;
            cnt_nxt = acc_cyc;
          end else if (is_seq) begin
            state_nxt = nvsc_pkg::NVSC_BUSY;
            cnt_nxt = cyc(PROC_CYC); // see R9
          end else begin
            state_nxt = nvsc_pkg::NVSC_IDLE;
          end
        end
      end
      nvsc_pkg::NVSC_HWREQ: begin
        if (cnt_done) begin
          state_nxt = nvsc_pkg::NVSC_BUSY;
          cnt_nxt = cyc(nvsc_pkg::HW_SAVE_RELEASE_TIME_CYC + 2); // see R13
        end
      end
      nvsc_pkg::NVSC_BUSY: begin
        // wait out processing and any busy indication; no access meanwhile
        if (cnt_done && !dev_busy) state_nxt = nvsc_pkg::NVSC_IDLE; // see R10
      end
      default: state_nxt = nvsc_pkg::NVSC_IDLE;
    endcase
  end

  // pin decode; write strobe only for plain writes, never in a command
  wire in_acc  = (state_nxt == nvsc_pkg::NVSC_ACCESS);
  wire cmd_seq = in_acc && (state_r == nvsc_pkg::NVSC_IDLE ? i_req_cmd[1] : is_seq);
  wire cmd_wr  = in_acc && (state_r == nvsc_pkg::NVSC_IDLE ? (i_req_cmd == nvsc_pkg::CMD_WRITE) : is_write);
  wire cmd_rec = (state_r == nvsc_pkg::NVSC_IDLE) ? (i_req_cmd == nvsc_pkg::CMD_SW_RESTORE)
                                                   : (cmd_r == nvsc_pkg::CMD_SW_RESTORE);
  wire [14:0] addr_nxt = cmd_seq ? seq_addr(seq_idx_nxt, cmd_rec)
                                 : ((state_r == nvsc_pkg::NVSC_IDLE) ? i_req_addr : uaddr_r);
  wire [7:0] wd_nxt = (state_r == nvsc_pkg::NVSC_IDLE) ? i_req_wdata : wdata_r;
  // next pin and response values; the flops below only copy them
  wire        sel_n_nxt    = !in_acc; // see R6 see R15
  wire        wr_n_nxt     = !cmd_wr; // see R8
  wire        oe_n_nxt     = !(in_acc && !cmd_wr);
  wire        pull_nxt     = (state_nxt == nvsc_pkg::NVSC_HWREQ); // see R12
  wire        ready_nxt    = (state_nxt == nvsc_pkg::NVSC_IDLE);
  wire [14:0] pin_addr_nxt = in_acc ? addr_nxt : o_mem_addr;
  wire [7:0]  rdata_nxt    = rsp_fire ? dq_s : o_rsp_rdata;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_r <= nvsc_pkg::NVSC_POWERUP;
      cnt_r <= cyc(POWERUP_CYC);
      seq_idx_r <= '0;
      cmd_r <= nvsc_pkg::CMD_READ;
      wdata_r <= '0;
      uaddr_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      seq_idx_r <= seq_idx_nxt;
      cmd_r <= cmd_nxt;
      wdata_r <= wdata_nxt;
      uaddr_r <= uaddr_nxt;
    end
  end

  // memory side pins
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_mem_addr <= '0;
      o_mem_sel_n <= 1'b1;
      o_mem_wr_n <= 1'b1;
      o_mem_oe_n <= 1'b1;
      o_mem_dq <= '0;
      o_mem_dq_oe <= 1'b0;
      o_hw_save_busy_n <= 1'b1;
      o_hw_save_busy_oe <= 1'b0;
    end else begin
      o_mem_addr <= pin_addr_nxt;
      o_mem_sel_n <= sel_n_nxt;
      o_mem_wr_n <= wr_n_nxt;
      o_mem_oe_n <= oe_n_nxt;
      o_mem_dq <= wd_nxt;
      o_mem_dq_oe <= cmd_wr;
      // busy pin only pulled low while requesting, never driven high against the device
      o_hw_save_busy_n <= 1'b0; // see R14
      o_hw_save_busy_oe <= pull_nxt;
    end
  end

  // user side
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_req_ready <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_rsp_rdata <= '0;
    end else begin
      o_req_ready <= ready_nxt;
      o_rsp_valid <= done_fire;
      o_rsp_rdata <= rdata_nxt;
    end
  end
endmodule : nvsc_host
`default_nettype wire

// ==== rtl/nvsc_pkg.sv ====
// package: timing constants, command addresses and states for the nvsram host controller
// Overview of operation
// R1: device skips hardware or power-loss save when nothing was written since last nonvolatile operation
// R2: device keeps accepting writes briefly after a save starts, then locks the array
// R3: that write grace interval lasts at most 25 ns
// R4: device ignores reads and writes during save, restore, or low supply
// R5: power-up restore time counts from supply passing trip level; access blocked meanwhile
// R6: host issues command sequence as reads clocked by chip select or output enable
// R7: host performs six consecutive reads of fixed addresses in order, nothing between
// R8: host holds write strobe high throughout all six command reads
// R9: device acts on a valid command within 100 us after sixth read
// R10: save and restore commands lock out all host access until complete
// R11: sixth command read data may be invalid; host must not use it
// R12: host requests hardware save by driving store/busy low at least 15 ns
// R13: with no write latched, device restores outputs within 25 ns, no save
// R14: host keeps store/busy high during every normal read or write
// R15: strobe decode: deselect, write, read with output enable, else high impedance
// R16: out-of-order or wrong-address command read discards sequence, treated as ordinary read
package nvsc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // access strobe timing, least times round up
  localparam int READ_CYCLE_NS = 25;
  localparam int READ_CYCLE_CYC = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_ACCESS_NS = 25;
  localparam int DATA_ACCESS_CYC = (DATA_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_NS = 20;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HW_SAVE_PULSE_MIN_NS = 15;
  localparam int HW_SAVE_PULSE_MIN_CYC = (HW_SAVE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HW_SAVE_RELEASE_TIME_NS = 25;
  localparam int HW_SAVE_RELEASE_TIME_CYC = (HW_SAVE_RELEASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_GRACE_TIME_NS = 25;
  localparam int WRITE_GRACE_TIME_CYC = (WRITE_GRACE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COMMAND_PROCESSING_TIME_US = 100;
  localparam int COMMAND_PROCESSING_TIME_CYC = COMMAND_PROCESSING_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int POWERUP_RESTORE_TIME_MS = 20;
  localparam int POWERUP_RESTORE_TIME_CYC = POWERUP_RESTORE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CNT_W = 24;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int SEQ_LEN = 6;
  // command sequence addresses, first five common
  localparam logic [14:0] SEQ_A0 = 15'h0E38;
  localparam logic [14:0] SEQ_A1 = 15'h31C7;
  localparam logic [14:0] SEQ_A2 = 15'h03E0;
  localparam logic [14:0] SEQ_A3 = 15'h3C1F;
  localparam logic [14:0] SEQ_A4 = 15'h303F;
  localparam logic [14:0] SEQ_STORE = 15'h0FC0;
  localparam logic [14:0] SEQ_RECALL = 15'h0C63;
  localparam logic [1:0] CMD_READ = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_SW_SAVE = 2'h2;
  localparam logic [1:0] CMD_SW_RESTORE = 2'h3;
  typedef enum logic [2:0] {
    NVSC_POWERUP = 3'b000,
    NVSC_IDLE    = 3'b001,
    NVSC_ACCESS  = 3'b011,
    NVSC_GAP     = 3'b010,
    NVSC_HWREQ   = 3'b110,
    NVSC_BUSY    = 3'b111
  } nvsc_state_t;
endpackage : nvsc_pkg

// ==== rtl/nvsc_sync.sv ====
// two-flop synchroniser for pins
`timescale 1ns/1ps
`default_nettype none
module nvsc_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_r;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= '1;
      o_sync <= '1;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule : nvsc_sync
`default_nettype wire

// ==== tb/nvsc_host_asserts.sv ====
// pin-level checks on the nvsram host controller
`timescale 1ns/1ps
`default_nettype none
module nvsc_host_asserts (
  input wire logic        i_clk_sys,
  input wire logic        i_rst,
  input wire logic        o_rsp_valid,
  input wire logic [14:0] o_mem_addr,
  input wire logic        o_mem_sel_n,
  input wire logic        o_mem_wr_n,
  input wire logic        o_mem_oe_n,
  input wire logic        o_mem_dq_oe,
  input wire logic        o_hw_save_busy_n,
  input wire logic        o_hw_save_busy_oe
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  a_oe_needs_sel:
    assert property (!o_mem_oe_n |-> !o_mem_sel_n) else $error("output enable without select");
  a_read_min_len:
    assert property ($fell(o_mem_oe_n) |-> !o_mem_oe_n [*3]) else $error("read strobe too short");
  a_addr_held:
    assert property (!o_mem_sel_n ##1 !o_mem_sel_n |-> $stable(o_mem_addr)) else $error("address moved in cycle");
  a_read_wr_high:
    assert property (!o_mem_oe_n |-> o_mem_wr_n) else $error("write strobe low during read");
  a_save_pulse_min:
    assert property ($rose(o_hw_save_busy_oe) |-> o_hw_save_busy_oe [*2]) else $error("save pulse too short");
  a_busy_pin_idle:
    assert property (!o_mem_sel_n |-> !o_hw_save_busy_oe) else $error("busy pin pulled during access");
  a_dq_drive_write:
    assert property (o_mem_dq_oe == !o_mem_wr_n) else $error("data bus driven outside a write");
  a_busy_pull_low:
    assert property (o_hw_save_busy_oe |-> !o_hw_save_busy_n) else $error("busy pin driven high");
  c_hw_save: cover property ($rose(o_hw_save_busy_oe));
  c_write: cover property ($fell(o_mem_wr_n));
  c_rsp: cover property (o_rsp_valid);
endmodule : nvsc_host_asserts
bind nvsc_host nvsc_host_asserts nvsc_host_asserts_inst (.i_clk_sys, .i_rst, .o_rsp_valid, .o_mem_addr,
  .o_mem_sel_n, .o_mem_wr_n, .o_mem_oe_n, .o_mem_dq_oe, .o_hw_save_busy_n, .o_hw_save_busy_oe);
`default_nettype wire

// ==== tb/nvsc_mem_model.sv ====
// behavioural nvsram seen at its pins
`timescale 1ns/1ps
`default_nettype none
module nvsc_mem_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_slow,
  input  wire logic [14:0] i_addr,
  input  wire logic        i_sel_n,
  input  wire logic        i_wr_n,
  input  wire logic        i_oe_n,
  input  wire logic [7:0]  i_dq,
  input  wire logic        i_busy_oe,
  output logic      [7:0]  o_dq,
  output logic             o_busy_n,
  output logic      [7:0]  o_nv_ops
);
  logic [7:0]  mem [32768];
  logic [7:0]  nv [32768];
  logic [7:0]  last_r = 8'h00;
  logic [15:0] busy_r;
  logic [2:0]  seq_r;
  logic        latch_r, lock_r;
  logic        rd_r = 1'b0;
  logic        hs_r = 1'b0;
  function automatic logic [14:0] sq(input logic [2:0] k);
    case (k)
      3'h0: sq = nvsc_pkg::SEQ_A0;
      3'h1: sq = nvsc_pkg::SEQ_A1;
      3'h2: sq = nvsc_pkg::SEQ_A2;
      3'h3: sq = nvsc_pkg::SEQ_A3;
      default: sq = nvsc_pkg::SEQ_A4;
    endcase
  endfunction : sq
  wire         rd_on = !i_sel_n && !i_oe_n && i_wr_n;
  wire  [15:0] btime = i_slow ? 16'h00C8 : 16'h0014;
  // released bus toggles so a stale byte never looks valid
  assign o_dq = (rd_on && busy_r == 0 && seq_r != 3'h5) ? mem[i_addr] : ~last_r;
  assign o_busy_n = (busy_r == 0);
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      busy_r <= 16'h000F;
      seq_r <= 3'h0;
      lock_r <= 1'b1;
      latch_r <= 1'b0;
      o_nv_ops <= 8'h00;
    end else begin
      lock_r <= (busy_r != 0);
      rd_r <= rd_on;
      hs_r <= i_busy_oe;
      last_r <= o_dq;
      if (busy_r != 0) begin
        busy_r <= busy_r - 16'h0001;
      end else if (i_busy_oe && !hs_r && latch_r) begin
        busy_r <= btime;
        for (int k = 0; k < 32768; k++) nv[k] <= mem[k];
        latch_r <= 1'b0;
        o_nv_ops <= o_nv_ops + 8'h01;
      end else if (rd_on && !rd_r) begin
        if (seq_r == 3'h5 && (i_addr == nvsc_pkg::SEQ_STORE || i_addr == nvsc_pkg::SEQ_RECALL)) begin
          busy_r <= btime;
          o_nv_ops <= o_nv_ops + 8'h01;
          seq_r <= 3'h0;
          latch_r <= 1'b0;
          for (int k = 0; k < 32768; k++) begin
            if (i_addr == nvsc_pkg::SEQ_STORE) nv[k] <= mem[k];
            else mem[k] <= nv[k];
          end
        end else if (seq_r < 3'h5 && i_addr == sq(seq_r)) seq_r <= seq_r + 3'h1;
        else seq_r <= {2'b00, i_addr == sq(3'h0)};
      end
      if (!i_sel_n && !i_wr_n && !lock_r) begin
        mem[i_addr] <= i_dq;
        latch_r <= 1'b1;
      end
    end
  end
endmodule : nvsc_mem_model
`default_nettype wire

// ==== tb/tb_nvsc_host.sv ====
// testbench for the nvsram host controller
`timescale 1ns/1ps
`default_nettype none
module tb_nvsc_host;
  logic        clk, rst, vld, hwr, slow, rdy, rv, sel_n, wr_n, oe_n, dqoe, hbo, hbd, mbn;
  logic [1:0]  cmd;
  logic [14:0] adr, ma;
  logic [7:0]  wd, rd, mdq, odq, nvc;
  logic [8:0]  q [$];
  logic [14:0] a [4];
  logic [7:0]  d [4];
  int          err_total, tests_run, seed, n;
  wire  [7:0]  dqin = dqoe ? odq : mdq;
  wire         hbn = (hbo ? hbd : 1'b1) & mbn;
  nvsc_host #(.POWERUP_CYC(20), .PROC_CYC(10)) nvsc_host_inst (.i_clk_sys(clk), .i_rst(rst), .i_req_valid(vld),
    .i_req_cmd(cmd), .i_req_addr(adr), .i_req_wdata(wd), .i_hw_save_req(hwr), .o_req_ready(rdy), .o_rsp_valid(rv),
    .o_rsp_rdata(rd), .o_mem_addr(ma), .o_mem_sel_n(sel_n), .o_mem_wr_n(wr_n), .o_mem_oe_n(oe_n), .i_mem_dq(dqin),
    .o_mem_dq(odq), .o_mem_dq_oe(dqoe), .i_hw_save_busy_n(hbn), .o_hw_save_busy_n(hbd), .o_hw_save_busy_oe(hbo));
  nvsc_mem_model nvsc_mem_model_inst (.i_clk_sys(clk), .i_rst(rst), .i_slow(slow), .i_addr(ma), .i_sel_n(sel_n),
    .i_wr_n(wr_n), .i_oe_n(oe_n), .i_dq(odq), .i_busy_oe(hbo), .o_dq(mdq), .o_busy_n(mbn), .o_nv_ops(nvc));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  task automatic fail(input string m);
    err_total++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : fail
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) fail("value mismatch");
  endtask : chk
  // one request, held until the controller takes it
  task automatic req(input logic h, input logic [1:0] c, input logic [14:0] ad, input logic [7:0] dt, input logic cm);
    q.push_back({cm, dt});
    @(negedge clk);
    hwr = h;
    vld = !h;
    cmd = c;
    adr = ad;
    wd = dt;
    n = 0;
    while (rdy !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    if (n == 5000) begin
      fail("ready timeout");
      end_sim();
    end
    @(negedge clk);
    vld = 1'b0;
    hwr = 1'b0;
  endtask : req
  task automatic drain;
    n = 0;
    while (q.size() != 0 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    if (n == 5000) begin
      fail("response timeout");
      end_sim();
    end
  endtask : drain
  always @(negedge clk) begin
    if (rv === 1'b1) begin
      if (q.size() == 0) fail("response without request");
      else if (q[0][8]) chk(rd, q[0][7:0]);
      if (q.size() != 0) void'(q.pop_front());
    end
  end
  initial begin
    seed = 40;
    err_total = 0;
    tests_run = 0;
    {rst, vld, hwr, slow, cmd, adr, wd} = {1'b1, 28'h0000000};
    repeat (10) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      a[i] = (i == 3) ? 15'h7FFF : {2'(i), 13'($random(seed))};
      d[i] = 8'($random(seed));
      req(1'b0, nvsc_pkg::CMD_WRITE, a[i], d[i], 1'b0);
    end
    for (int i = 0; i < 4; i++) req(1'b0, nvsc_pkg::CMD_READ, a[i], d[i], 1'b1);
    for (int i = 0; i < 2; i++) begin
      req(1'b1, nvsc_pkg::CMD_READ, 15'h0000, 8'h00, 1'b0);
      drain();
      chk(nvc, 8'h01);
    end
    slow = 1'b1;
    req(1'b0, nvsc_pkg::CMD_SW_SAVE, 15'h0000, 8'h00, 1'b0);
    drain();
    chk(nvc, 8'h02);
    slow = 1'b0;
    req(1'b0, nvsc_pkg::CMD_WRITE, a[0], ~d[0], 1'b0);
    req(1'b0, nvsc_pkg::CMD_SW_RESTORE, 15'h0000, 8'h00, 1'b0);
    req(1'b0, nvsc_pkg::CMD_READ, a[0], d[0], 1'b1);
    drain();
    chk(nvc, 8'h03);
    end_sim();
  end
endmodule : tb_nvsc_host
`default_nettype wire
